// ===== hw/qrd_read_core.sv
// Purpose: four-lane single and double rate read path of a serial flash
// Assumes: mem_data_i shows the byte at mem_addr_o one clk_sys_i cycle after it changes
// Notes: serial clock, chip select and lanes are sampled, edges found on clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module qrd_read_core #(
   parameter int ADDR_W = 32
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic sck_i,
   input wire logic cs_b_i,
   input wire logic [3:0] lane_bus_i,
   output logic [3:0] lane_bus_o,
   output logic [3:0] lane_bus_oe_o,
   input wire logic cfg_quad_en_i,
   input wire logic cfg_four_wire_en_i,
   input wire logic cfg_four_wire_cmd_i,
   input wire logic cfg_addr_wide_i,
   input wire logic [qrd_pkg::LAT_W-1:0] cfg_latency_i,
   input wire logic cfg_preamble_en_i,
   input wire logic [7:0] cfg_preamble_i,
   input wire logic mode_reset_i,
   input wire logic [7:0] mem_data_i,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic cont_sdr_o,
   output logic cont_ddr_o,
   output logic frame_busy_o
);

   // ***************************************************
   // link sampling and edge detection
   // ***************************************************

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_ADDR,
      ST_MODE,
      ST_DUMMY,
      ST_DATA,
      ST_IGNORE
   } qrd_state_t;

   logic [qrd_pkg::LINK_W-1:0] sync_w;
   logic sck_s;
   logic cs_s;
   logic [3:0] lane_s;
   logic sck_d_q;
   logic cs_d_q;

   qrd_sync #(
      .W(qrd_pkg::LINK_W),
      .RST_VAL(qrd_pkg::LINK_SYNC_RST)
   ) u_sync (
      .clk_sys_i(clk_sys_i),
      .rst_b_i(rst_b_i),
      .d_i({sck_i, cs_b_i, lane_bus_i}),
      .q_o(sync_w)
   );

   assign sck_s = sync_w[5];
   assign cs_s = sync_w[4];
   assign lane_s = sync_w[3:0];

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sck_d_q <= 1'b0;
         cs_d_q <= 1'b1;
      end else begin
         sck_d_q <= sck_s;
         cs_d_q <= cs_s;
      end
   end

   // ***************************************************
   // state and datapath registers
   // ***************************************************

   qrd_state_t st_q;
   logic [5:0] cnt_q;
   logic [31:0] sh_q;
   logic ddr_q;
   logic wide_q;
   logic mode_ok_q;
   logic mode_seen_q;
   logic cont_sdr_q;
   logic cont_ddr_q;
   logic hi_q;
   logic oe_q;
   logic [3:0] lane_q;
   logic [ADDR_W-1:0] addr_q;

   // ***************************************************
   // decode
   // ***************************************************

   wire sck_rise_w = sck_s & ~sck_d_q;
   wire sck_fall_w = ~sck_s & sck_d_q;
   wire cs_fall_w = ~cs_s & cs_d_q;
   wire cs_rise_w = cs_s & ~cs_d_q;
   // capture edges: both edges in double rate, rising only otherwise
   wire edge_w = ddr_q ? (sck_rise_w | sck_fall_w) : sck_rise_w; // R15
   // drive edges: both edges in double rate, falling only otherwise
   wire out_edge_w = ddr_q ? (sck_rise_w | sck_fall_w) : sck_fall_w; // R6 R15

   wire [31:0] sh_nib_w = {sh_q[27:0], lane_s};
   wire [31:0] sh_bit_w = {sh_q[30:0], lane_s[0]};
   wire [7:0] op_w = cfg_four_wire_cmd_i ? sh_nib_w[7:0] : sh_bit_w[7:0]; // R14 R22
   wire [5:0] cmd_last_w = cfg_four_wire_cmd_i ? qrd_pkg::CMD_NIBS_LAST
                                               : qrd_pkg::CMD_BITS_LAST;
   wire cmd_done_w = (cnt_q == cmd_last_w);
   wire op_sdr_w = (op_w == qrd_pkg::OP_SDR_NARROW) | (op_w == qrd_pkg::OP_SDR_WIDE);
   wire op_ddr_w = (op_w == qrd_pkg::OP_DDR_NARROW) | (op_w == qrd_pkg::OP_DDR_WIDE);
   wire op_wide_w = (op_w == qrd_pkg::OP_SDR_WIDE) | (op_w == qrd_pkg::OP_DDR_WIDE);
   wire quad_ok_w = cfg_quad_en_i | cfg_four_wire_en_i; // R3
   wire read_ok_w = (op_sdr_w | op_ddr_w) & quad_ok_w; // R3

   wire [5:0] addr_last_w = wide_q ? qrd_pkg::ADDR_WIDE_LAST
                                   : qrd_pkg::ADDR_NARROW_LAST; // R1 R2
   wire [ADDR_W-1:0] addr_in_w = wide_q ? ADDR_W'(sh_nib_w)
                                        : ADDR_W'(sh_nib_w[qrd_pkg::NARROW_ADDR_W-1:0]);
   // first address nibble only on a rising edge: skips the fall that ends the opcode cycle
   wire addr_edge_w = edge_w & (sck_rise_w | (cnt_q != '0)); // R15

   wire mode_sdr_ok_w = (sh_nib_w[7:4] == qrd_pkg::MODE_SDR_KEEP); // R8
   wire mode_ddr_ok_w = (sh_nib_w[7:4] == ~sh_nib_w[3:0]); // R17
   wire mode_ok_w = ddr_q ? mode_ddr_ok_w : mode_sdr_ok_w;

   // dummy length counted in capture edges of the current rate
   wire [5:0] dum_total_w = ddr_q ? {1'b0, cfg_latency_i, 1'b0}
                                  : {2'b00, cfg_latency_i}; // R5
   wire dum_done_w = (cnt_q == dum_total_w);
   // preamble covers the last eight dummy edges of a double rate read
   wire [5:0] pre_pos_w = 6'(cnt_q + qrd_pkg::PRE_EDGES);
   wire pre_act_w = ddr_q & cfg_preamble_en_i & (pre_pos_w >= dum_total_w) & ~dum_done_w;
   wire [5:0] pre_idx_w = 6'(pre_pos_w - dum_total_w);
   wire [7:0] pre_sel_w = 8'(cfg_preamble_i << pre_idx_w[2:0]);
   wire [3:0] pre_lane_w = {4{pre_sel_w[7]}}; // R21

   wire [3:0] data_nib_w = hi_q ? mem_data_i[7:4] : mem_data_i[3:0]; // R23

   // ***************************************************
   // frame state machine
   // ***************************************************

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q <= ST_IDLE;
         cnt_q <= '0;
         sh_q <= '0;
         ddr_q <= 1'b0;
         wide_q <= 1'b0;
         mode_ok_q <= 1'b0;
         mode_seen_q <= 1'b0;
      end else if (cs_rise_w) begin
         st_q <= ST_IDLE;
      end else if (cs_fall_w) begin
         cnt_q <= '0;
         mode_seen_q <= 1'b0;
         if (cont_ddr_q) begin
            st_q <= ST_ADDR; // R17
            ddr_q <= 1'b1;
         end else if (cont_sdr_q) begin
            st_q <= ST_ADDR; // R8
            ddr_q <= 1'b0;
         end else begin
            st_q <= ST_CMD;
            ddr_q <= 1'b0;
         end
      end else begin
         case (st_q)
            ST_CMD: begin
               if (sck_rise_w) begin
                  sh_q <= cfg_four_wire_cmd_i ? sh_nib_w : sh_bit_w; // R14 R22
                  cnt_q <= 6'(cnt_q + 1'b1);
                  if (cmd_done_w) begin
                     cnt_q <= '0;
                     st_q <= read_ok_w ? ST_ADDR : ST_IGNORE; // R3
                     ddr_q <= op_ddr_w;
                     wide_q <= op_wide_w | cfg_addr_wide_i; // R1 R2
                  end
               end
            end
            ST_ADDR: begin
               if (addr_edge_w) begin
                  sh_q <= sh_nib_w; // R4 R15
                  cnt_q <= 6'(cnt_q + 1'b1);
                  if (cnt_q == addr_last_w) begin
                     cnt_q <= '0;
                     st_q <= ST_MODE;
                  end
               end
            end
            ST_MODE: begin
               if (edge_w) begin
                  sh_q <= sh_nib_w;
                  cnt_q <= 6'(cnt_q + 1'b1);
                  if (cnt_q == qrd_pkg::MODE_NIBS_LAST) begin
                     cnt_q <= '0; // R11
                     mode_ok_q <= mode_ok_w; // R8 R17
                     mode_seen_q <= 1'b1;
                     st_q <= ST_DUMMY;
                  end
               end
            end
            ST_DUMMY: begin
               // lanes are not sampled while waiting
               if (out_edge_w && dum_done_w) begin
                  st_q <= ST_DATA; // R5
               end else if (edge_w && !dum_done_w) begin
                  cnt_q <= 6'(cnt_q + 1'b1); // R5
               end
            end
            ST_DATA, ST_IGNORE, ST_IDLE: begin
               st_q <= st_q;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   // ***************************************************
   // lane drive and read address
   // ***************************************************

   wire data_start_w = (st_q == ST_DUMMY) & out_edge_w & dum_done_w & ~cs_rise_w;
   wire data_step_w = (st_q == ST_DATA) & out_edge_w & ~cs_rise_w;
   wire pre_step_w = (st_q == ST_DUMMY) & edge_w & pre_act_w & ~cs_rise_w;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lane_q <= '0;
         oe_q <= 1'b0;
         hi_q <= 1'b1;
         addr_q <= '0;
      end else if (cs_rise_w || cs_fall_w) begin
         oe_q <= 1'b0; // R12
         hi_q <= 1'b1;
      end else if (st_q == ST_ADDR && addr_edge_w && cnt_q == addr_last_w) begin
         addr_q <= addr_in_w;
      end else if (pre_step_w) begin
         lane_q <= pre_lane_w; // R19 R20 R21
         oe_q <= 1'b1;
      end else if (data_start_w || data_step_w) begin
         lane_q <= data_nib_w; // R6 R23
         oe_q <= 1'b1; // R12
         hi_q <= ~hi_q;
         if (!hi_q) begin
            addr_q <= ADDR_W'(addr_q + 1'b1); // R7
         end
      end
   end

   // ***************************************************
   // continuous read flags
   // ***************************************************

   wire frame_set_w = cs_rise_w & mode_seen_q & mode_ok_q;
   wire frame_clr_w = cs_rise_w & mode_seen_q & ~mode_ok_q;
   // a frame cut inside mode leaves the mode bits unknown: drop out
   wire frame_cut_w = cs_rise_w & (st_q == ST_MODE); // R13

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cont_sdr_q <= 1'b0;
         cont_ddr_q <= 1'b0;
      end else if (frame_set_w) begin
         cont_sdr_q <= ~ddr_q; // R8
         cont_ddr_q <= ddr_q; // R17
      end else if (frame_clr_w || frame_cut_w || mode_reset_i) begin
         cont_sdr_q <= 1'b0; // R9 R10
         cont_ddr_q <= 1'b0; // R18 R10
      end
   end

   assign lane_bus_o = lane_q;
   assign lane_bus_oe_o = {4{oe_q}};
   assign mem_addr_o = addr_q;
   assign cont_sdr_o = cont_sdr_q;
   assign cont_ddr_o = cont_ddr_q;
   assign frame_busy_o = (st_q != ST_IDLE);

   // ***************************************************
   // checks
   // ***************************************************

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);

   AST_QUAD_GATE: assert property ( // R3
      (st_q == ST_CMD) && sck_rise_w && cmd_done_w && !quad_ok_w && !cs_rise_w && !cs_fall_w
      |=> (st_q == ST_IGNORE))
      else $error("read command taken with four-lane access disabled");

   AST_ADDR_LEN: assert property ( // R1
      $rose(st_q == ST_MODE) |-> ($past(cnt_q) == addr_last_w))
      else $error("address phase length does not match address width");

   AST_MODE_LEN: assert property ( // R11
      $rose(st_q == ST_DUMMY) |-> ($past(cnt_q) == qrd_pkg::MODE_NIBS_LAST))
      else $error("mode phase is not two nibbles");

   AST_DUMMY_LEN: assert property ( // R5
      $rose(st_q == ST_DATA) |-> ($past(cnt_q) == dum_total_w))
      else $error("data started before configured latency");

   AST_SDR_FALL: assert property ( // R6
      (st_q == ST_DATA) && !ddr_q && !sck_fall_w |=> $stable(lane_q))
      else $error("single rate data changed off a falling edge");

   AST_ADDR_STEP: assert property ( // R7
      data_step_w && !hi_q |=> (mem_addr_o == ADDR_W'($past(mem_addr_o) + 1'b1)))
      else $error("read address did not advance after a byte");

   AST_CONT_KEEP: assert property ( // R8
      frame_set_w |=> ($past(ddr_q) ? cont_ddr_q : cont_sdr_q))
      else $error("continuous read not kept after valid mode byte");

   AST_CONT_LEAVE: assert property ( // R9
      frame_clr_w |=> !cont_sdr_q && !cont_ddr_q)
      else $error("continuous read kept after non-matching mode byte");

   AST_MODE_RESET: assert property ( // R10
      mode_reset_i && !frame_set_w |=> !cont_sdr_q && !cont_ddr_q)
      else $error("mode reset did not clear continuous read");

   AST_PREAMBLE_END: assert property ( // R19
      $rose(st_q == ST_DATA) && ddr_q && cfg_preamble_en_i && (cfg_latency_i >= 4'h4)
      |-> $past(oe_q) && ($past(lane_q) == {4{cfg_preamble_i[0]}}))
      else $error("preamble did not end with its last bit on all lanes");

   AST_OE_RELEASE: assert property ( // R12
      cs_rise_w |=> !oe_q [*2])
      else $error("lanes still driven after frame end");

endmodule
`default_nettype wire

// ===== hw/qrd_pkg.sv
// Purpose: shared constants of the four-lane read path
// Assumes: link signals sampled by clk_sys_i, at least four samples per serial clock phase
// Notes: opcodes, phase lengths and reset patterns live here only
//
// Notes on behaviour
// R1 - single rate read: narrow opcode follows width bit, wide opcode always four bytes
// R2 - double rate read: narrow opcode follows width bit, wide opcode always four bytes
// R3 - four-lane reads accepted only if lane enable or four-wire enable is set
// R4 - single rate address moves four bits per serial clock on all lanes
// R5 - configured dummy cycles follow the mode byte, lane values ignored there
// R6 - single rate data nibble driven at each falling serial clock edge
// R7 - read address increments per byte and wraps to zero at the top
// R8 - single rate mode upper nibble A keeps continuous read, next frame skips opcode
// R9 - any other single rate mode value leaves continuous read at frame end
// R10 - mode reset command drops either continuous read mode
// R11 - mode byte takes two cycles right after the address; code takes two capture edges, which is one cycle in double rate
// R12 - host releases lanes before first data falling edge
// R13 - host keeps chip select low through mode and dummy cycles
// R14 - four-wire command mode sends single rate opcode four bits per rising edge
// R15 - double rate address, mode and data move four bits on each edge
// R16 - host keeps double rate clock within its maximum frequency
// R17 - complementary double rate mode nibbles enter continuous read
// R18 - non-complementary double rate mode leaves continuous read after next frame end; code leaves it at the end of the frame carrying the mode
// R19 - enabled preamble driven during the four cycles before first data
// R20 - host leaves lanes undriven through dummy cycles when preamble enabled
// R21 - programmable preamble byte, msb first, same on all four lanes
// R22 - four-wire command mode sends double rate opcode four bits per rising edge
// R23 - each data byte goes out upper nibble first, then lower nibble

package qrd_pkg;
   localparam logic [7:0] OP_SDR_NARROW = 8'hEB;
   localparam logic [7:0] OP_SDR_WIDE = 8'hEC;
   localparam logic [7:0] OP_DDR_NARROW = 8'hED;
   localparam logic [7:0] OP_DDR_WIDE = 8'hEE;
   localparam logic [5:0] CMD_BITS_LAST = 6'h07;
   localparam logic [5:0] CMD_NIBS_LAST = 6'h01;
   localparam logic [5:0] ADDR_NARROW_LAST = 6'h05;
   localparam logic [5:0] ADDR_WIDE_LAST = 6'h07;
   localparam logic [5:0] MODE_NIBS_LAST = 6'h01;
   localparam logic [3:0] MODE_SDR_KEEP = 4'hA;
   localparam logic [5:0] PRE_EDGES = 6'h08;
   localparam int NARROW_ADDR_W = 24;
   localparam int LAT_W = 4;
   localparam int LINK_W = 6;
   localparam logic [5:0] LINK_SYNC_RST = 6'h10;
endpackage

// ===== hw/qrd_sync.sv
// Purpose: two-flop synchroniser for a group of link pins
// Assumes: each bit is an independent level
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module qrd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_sys_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule
`default_nettype wire

// ===== dv/qrd_host_model.sv
// Purpose: host controller model driving serial clock, chip select and lanes
// Assumes: each serial clock phase lasts four clk_sys_i cycles (800 ns period)
// Notes: got holds the lane levels seen just before each serial clock edge
`timescale 1ns/1ps
`default_nettype none
module qrd_host_model (
   input wire logic clk_sys_i,
   output logic sck_o,
   output logic cs_b_o,
   output logic [3:0] lane_o,
   output logic lane_oe_o,
   input wire logic [3:0] lane_i
);
   logic [3:0] got[$];
   // ****************************************
   // frame sequencing
   // ****************************************
   initial begin
      sck_o = 1'b0;
      cs_b_o = 1'b1;
      lane_o = 4'h0;
      lane_oe_o = 1'b0;
   end
   task automatic q();
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask
   // one serial clock edge; lanes settle half a phase before it
   task automatic step(input logic [3:0] v, input bit drv);
      lane_o = v;
      lane_oe_o = drv;
      q();
      got.push_back(lane_i);
      sck_o = ~sck_o;
      q();
   endtask
   task automatic pair(input logic [3:0] v);
      step(v, 1'b1);
      step(v, 1'b1);
   endtask
   task automatic frame(input bit ddr, input bit op_on, input bit op4, input logic [7:0] op,
         input int anib, input logic [31:0] addr, input logic [7:0] mode, input int tail);
      cs_b_o = 1'b0;
      q();
      q();
      for (int i = 0; i < (op_on ? (op4 ? 2 : 8) : 0); i++) begin
         pair(op4 ? op[7-4*i -: 4] : {3'b000, op[7-i]});
      end
      for (int i = anib - 1; i >= 0; i--) begin
         step(addr[4*i +: 4], 1'b1);
         if (!ddr) step(addr[4*i +: 4], 1'b1);
      end
      step(mode[7:4], 1'b1);
      if (!ddr) step(mode[7:4], 1'b1);
      step(mode[3:0], 1'b1);
      got.delete();
      for (int i = 0; i < tail; i++) step(4'h0, 1'b0);
      if (sck_o) step(4'h0, 1'b0);
      cs_b_o = 1'b1;
      repeat (4) q();
   endtask
endmodule
`default_nettype wire

// ===== dv/quad_io_sdr_ddr_read_test.sv
// Purpose: self-checking bench of the four-lane read path
// Assumes: host model frames; byte memory answers one cycle after the address
// Notes: lanes nobody drives show the inverse of their last level each cycle
`timescale 1ns/1ps
`default_nettype none
module quad_io_sdr_ddr_read_test;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic sck, cs_b, h_oe, mode_reset = 1'b0;
   logic [3:0] h_lane, lane_o, lane_oe, lane_w;
   logic [3:0] lane_last = 4'h0;
   logic quad_en = 1'b0, fw_en = 1'b0, fw_cmd = 1'b0, wide = 1'b0, pre_en = 1'b0;
   logic [3:0] lat = 4'h0;
   logic [7:0] pre = 8'h00, mem_data = 8'h00;
   logic [31:0] mem_addr;
   logic cont_sdr, cont_ddr, busy;
   int failures = 0, compares = 0, oe_cnt = 0;
   // ****************************************
   // environment
   // ****************************************
   always #50 clk_sys_i = ~clk_sys_i;
   assign lane_w = (lane_oe[0] === 1'b1) ? lane_o : (h_oe ? h_lane : ~lane_last);
   always @(posedge clk_sys_i) lane_last <= lane_w;
   always @(posedge clk_sys_i) if (lane_oe !== 4'h0) oe_cnt++;
   function automatic logic [7:0] mem_f(input logic [31:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3C;
   endfunction
   always @(posedge clk_sys_i) mem_data <= mem_f(mem_addr);
   qrd_host_model host (.clk_sys_i(clk_sys_i), .sck_o(sck), .cs_b_o(cs_b), .lane_o(h_lane),
      .lane_oe_o(h_oe), .lane_i(lane_w));
   qrd_read_core dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .sck_i(sck), .cs_b_i(cs_b),
      .lane_bus_i(lane_w), .lane_bus_o(lane_o), .lane_bus_oe_o(lane_oe),
      .cfg_quad_en_i(quad_en), .cfg_four_wire_en_i(fw_en), .cfg_four_wire_cmd_i(fw_cmd),
      .cfg_addr_wide_i(wide), .cfg_latency_i(lat), .cfg_preamble_en_i(pre_en),
      .cfg_preamble_i(pre), .mode_reset_i(mode_reset), .mem_data_i(mem_data),
      .mem_addr_o(mem_addr), .cont_sdr_o(cont_sdr), .cont_ddr_o(cont_ddr), .frame_busy_o(busy));
   // ****************************************
   // checking and closing
   // ****************************************
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic data_chk(input bit ddr, input int l, input logic [31:0] a, input int n);
      logic [7:0] b;
      int s;
      for (int k = 0; k < 2 * n; k++) begin
         b = mem_f(a + 32'(k / 2));
         s = ddr ? 2 * l + k + 1 : 2 * l + 2 * k + 1;
         check("data nibble", {28'h0, (k % 2) ? b[3:0] : b[7:4]}, {28'h0, host.got[s]});
      end
   endtask
   task automatic summarize();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys_i);
      failures++;
      summarize();
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (6) @(posedge clk_sys_i);
      #1 rst_b_i = 1'b1;
      repeat (2) host.q();
      quad_en = 1'b1;
      lat = 4'h2;
      host.frame(1'b0, 1'b1, 1'b0, 8'hEB, 6, 32'h0012_3456, 8'hA5, 20);
      data_chk(1'b0, 2, 32'h0012_3456, 4);
      check("cont sdr", 1, {31'h0, cont_sdr});
      $display("test sdr narrow done");
      lat = 4'h0;
      host.frame(1'b0, 1'b0, 1'b0, 8'h00, 6, 32'h0000_0010, 8'h5A, 8);
      data_chk(1'b0, 0, 32'h0000_0010, 2);
      check("cont sdr", 0, {31'h0, cont_sdr});
      $display("test sdr continuous done");
      fw_cmd = 1'b1;
      lat = 4'h1;
      host.frame(1'b0, 1'b1, 1'b1, 8'hEC, 8, 32'hFFFF_FFFF, 8'h00, 10);
      data_chk(1'b0, 1, 32'hFFFF_FFFF, 2);
      check("read address", 32'h0000_0001, mem_addr);
      fw_cmd = 1'b0;
      $display("test sdr wide wrap done");
      wide = 1'b1;
      lat = 4'h4;
      pre_en = 1'b1;
      pre = 8'h34;
      host.frame(1'b1, 1'b1, 1'b0, 8'hED, 8, 32'h0000_0100, 8'h5A, 15);
      for (int b = 0; b < 8; b++) begin
         check("preamble", {28'h0, {4{pre[7-b]}}}, {28'h0, host.got[1+b]});
      end
      data_chk(1'b1, 4, 32'h0000_0100, 3);
      check("cont ddr", 1, {31'h0, cont_ddr});
      host.frame(1'b1, 1'b0, 1'b0, 8'h00, 8, 32'h0000_0200, 8'h55, 13);
      data_chk(1'b1, 4, 32'h0000_0200, 2);
      check("cont ddr", 0, {31'h0, cont_ddr});
      $display("test ddr done");
      {quad_en, fw_en, fw_cmd, wide, pre_en, lat} = {5'b01100, 4'h1};
      host.frame(1'b1, 1'b1, 1'b1, 8'hEE, 8, 32'h0000_2000, 8'hC3, 7);
      data_chk(1'b1, 1, 32'h0000_2000, 2);
      check("cont ddr", 1, {31'h0, cont_ddr});
      mode_reset = 1'b1;
      host.q();
      mode_reset = 1'b0;
      host.q();
      check("cont ddr", 0, {31'h0, cont_ddr});
      $display("test four wire and mode reset done");
      fw_en = 1'b0;
      fw_cmd = 1'b0;
      oe_cnt = 0;
      host.frame(1'b0, 1'b1, 1'b0, 8'hEB, 6, 32'h0000_0040, 8'hA0, 6);
      quad_en = 1'b1;
      host.frame(1'b0, 1'b1, 1'b0, 8'h0B, 6, 32'h0000_0040, 8'hA0, 6);
      check("refused drive", 0, oe_cnt);
      check("cont sdr", 0, {31'h0, cont_sdr});
      check("busy after frame", 0, {31'h0, busy});
      $display("test refused done");
      summarize();
   end
endmodule
`default_nettype wire
